// >>> include/topo_pkg.sv
package topo_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_LEAF = 8'h00;
   localparam logic [7:0] OFF_SUB = 8'h04;
   localparam logic [7:0] OFF_LPSEL = 8'h08;
   localparam logic [7:0] OFF_RES_A = 8'h10;
   localparam logic [7:0] OFF_RES_B = 8'h14;
   localparam logic [7:0] OFF_RES_C = 8'h18;
   localparam logic [7:0] OFF_RES_D = 8'h1c;
   localparam logic [7:0] OFF_ICR = 8'h20;
   localparam logic [7:0] OFF_ROUTE = 8'h24;
   localparam logic [7:0] OFF_STAT = 8'h28;
   localparam logic [7:0] OFF_VEC = 8'h2c;
   // Leaf numbers
   localparam logic [31:0] LEAF_BASIC = 32'h0000_0000;
   localparam logic [31:0] LEAF_FEAT = 32'h0000_0001;
   localparam logic [31:0] LEAF_CORE = 32'h0000_0004;
   localparam logic [31:0] LEAF_TOPO = 32'h0000_000b;
   // Field positions
   localparam int MT_FLAG_BIT = 28;
   localparam int X2_FLAG_BIT = 21;
   localparam int ADDR_LP_LSB = 16;
   localparam int INIT_ID_LSB = 24;
   localparam int CORE_LSB = 26;
   localparam int TYPE_LSB = 8;
   localparam int ICR_DEST_LSB = 8;
   localparam int ROUTE_DEST_LSB = 8;
   localparam int ROUTE_EN_BIT = 16;
   localparam int STAT_BSP_LSB = 16;
   // Level type codes and cache type
   localparam logic [7:0] TYPE_SMT = 8'h01;
   localparam logic [7:0] TYPE_CORE = 8'h02;
   localparam logic [4:0] CACHE_DATA = 5'h01;
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RST_VEC = 8'h00;
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage

// >>> rtl/cpu_topology_enum.sv
// Function
// - Leaf 1 data_reg bit 28 flags multi-threading
// - Leaf 1 base_reg 23:16 addressable logical IDs
// - Leaf 4 accumulator_reg 31:26 cores minus one
// - Extended leaf reports unique 32-bit IDs
// - Single logical processor reports count one
// - Without extended leaf, leaf 0BH base_reg zero
// - Leaf 4 subleafs start at zero, valid below NUM_CACHE, higher ones read zero
// - Extended mode flag independent of extended leaf
// - Each logical processor holds unique ID
// - One bootstrap_processor, rest application_processor
// - Addressed IPI wakes halted processor at vector
// - interrupt_command_register write issues an IPI
// - External interrupts routed to chosen processor
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cpu_topology_enum #(
   parameter int NUM_LP = 4,
   parameter int THREADS = 2,
   parameter int NUM_CACHE = 4,
   parameter logic [31:0] MAX_LEAF = 32'h0000_000b,
   parameter bit HAS_TOPO = 1'b1,
   parameter bit MT_CAPABLE = 1'b1,
   parameter bit X2_CAPABLE = 1'b0,
   parameter logic [7:0] ID_BASE = 8'h00,
   // Arbitrary signature value
   parameter logic [31:0] SIGNATURE = 32'h0000_0a5c
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_irq,
   output logic [NUM_LP-1:0] lp_halted,
   output logic [NUM_LP*8-1:0] lp_vector
);
   localparam int IW = (NUM_LP > 1) ? $clog2(NUM_LP) : 1;
   localparam int CORES = NUM_LP / THREADS;
   localparam int SMT_SHIFT = (THREADS > 1) ? $clog2(THREADS) : 0;
   localparam int PKG_SHIFT = (NUM_LP > 1) ? $clog2(NUM_LP) : 0;
   localparam logic [7:0] ADDR_LP_CNT = (NUM_LP == 1) ? 8'h01 : 8'(1 << PKG_SHIFT);
   localparam logic [5:0] CORE_M1 = 6'(CORES - 1);

   // Parameter sanity
   if (NUM_LP < 1 || NUM_LP > 64 || THREADS < 1 || NUM_LP % THREADS != 0 ||
       NUM_CACHE < 1 || int'(ID_BASE) + NUM_LP > 256) begin : g_chk
      $error("cpu_topology_enum: unsupported parameters");
   end

   logic [31:0] leaf_ff;
   logic [31:0] sub_ff;
   logic [IW-1:0] lpsel_ff;
   logic [15:0] route_ff;
   logic route_en_ff;
   logic [31:0] hrdata_ff;
   logic wr_ff;
   logic [7:0] waddr_ff;
   logic ext_meta_ff;
   logic ext_sync_ff;
   logic ext_prev_ff;
   logic [NUM_LP-1:0] halted_ff;
   logic [7:0] vec_ff [NUM_LP];
   logic [31:0] res_a;
   logic [31:0] res_b;
   logic [31:0] res_c;
   logic [31:0] res_d;
   logic [7:0] sel_id;
   logic addr_ok;
   logic icr_fire;
   logic ext_fire;
   logic [7:0] icr_dest;
   logic [7:0] icr_vec;
   logic [7:0] nxt_rdata_sel;

   // Address phase accepted
   assign addr_ok = hsel && hready && (htrans == topo_pkg::HTRANS_NONSEQ) &&
                    (hsize == topo_pkg::HSIZE_WORD);
   assign nxt_rdata_sel = haddr[7:0];

   // Selected processor ID, unique by index
   assign sel_id = ID_BASE + 8'(lpsel_ff);

   // Identification responses, pure function of query registers
   always_comb begin
      res_a = topo_pkg::RST_WORD;
      res_b = topo_pkg::RST_WORD;
      res_c = topo_pkg::RST_WORD;
      res_d = topo_pkg::RST_WORD;
      if (int'(lpsel_ff) >= NUM_LP || leaf_ff > MAX_LEAF) begin
         res_a = topo_pkg::RST_WORD;
      end else if (leaf_ff == topo_pkg::LEAF_BASIC) begin
         res_a = MAX_LEAF;
      end else if (leaf_ff == topo_pkg::LEAF_FEAT) begin
         res_a = SIGNATURE;
         res_b[topo_pkg::INIT_ID_LSB +: 8] = sel_id;
         res_b[topo_pkg::ADDR_LP_LSB +: 8] = ADDR_LP_CNT;
         res_c[topo_pkg::X2_FLAG_BIT] = X2_CAPABLE;
         res_d[topo_pkg::MT_FLAG_BIT] = MT_CAPABLE;
      end else if (leaf_ff == topo_pkg::LEAF_CORE) begin
         // Subleafs from zero up to NUM_CACHE-1 carry the core count
         if (sub_ff < 32'(NUM_CACHE)) begin
            res_a[topo_pkg::CORE_LSB +: 6] = CORE_M1;
            res_a[4:0] = topo_pkg::CACHE_DATA;
         end
      end else if (leaf_ff == topo_pkg::LEAF_TOPO) begin
         // Extended leaf absent reads all zero
         if (HAS_TOPO) begin
            res_d = {24'h00_0000, sel_id};
            res_c[7:0] = sub_ff[7:0];
            if (sub_ff == 32'h0000_0000) begin
               res_a = 32'(SMT_SHIFT);
               res_b = 32'(THREADS);
               res_c[topo_pkg::TYPE_LSB +: 8] = topo_pkg::TYPE_SMT;
            end else if (sub_ff == 32'h0000_0001) begin
               res_a = 32'(PKG_SHIFT);
               res_b = 32'(NUM_LP);
               res_c[topo_pkg::TYPE_LSB +: 8] = topo_pkg::TYPE_CORE;
            end
         end
      end
   end

   // Data phase tracking for writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ff <= 1'b0;
         waddr_ff <= 8'h00;
      end else begin
         wr_ff <= addr_ok && hwrite;
         if (addr_ok) begin
            waddr_ff <= haddr[7:0];
         end
      end
   end

   // Read data captured at the address phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata_ff <= topo_pkg::RST_WORD;
      end else if (addr_ok && !hwrite) begin
         if (nxt_rdata_sel == topo_pkg::OFF_LEAF) begin
            hrdata_ff <= leaf_ff;
         end else if (nxt_rdata_sel == topo_pkg::OFF_SUB) begin
            hrdata_ff <= sub_ff;
         end else if (nxt_rdata_sel == topo_pkg::OFF_LPSEL) begin
            hrdata_ff <= 32'(lpsel_ff);
         end else if (nxt_rdata_sel == topo_pkg::OFF_RES_A) begin
            hrdata_ff <= res_a;
         end else if (nxt_rdata_sel == topo_pkg::OFF_RES_B) begin
            hrdata_ff <= res_b;
         end else if (nxt_rdata_sel == topo_pkg::OFF_RES_C) begin
            hrdata_ff <= res_c;
         end else if (nxt_rdata_sel == topo_pkg::OFF_RES_D) begin
            hrdata_ff <= res_d;
         end else if (nxt_rdata_sel == topo_pkg::OFF_ROUTE) begin
            hrdata_ff <= {15'h0000, route_en_ff, route_ff};
         end else if (nxt_rdata_sel == topo_pkg::OFF_STAT) begin
            hrdata_ff <= 32'(halted_ff);
            hrdata_ff[topo_pkg::STAT_BSP_LSB +: 8] <= ID_BASE;
         end else if (nxt_rdata_sel == topo_pkg::OFF_VEC) begin
            // Out of range selection reads zero, not an unknown
            if (int'(lpsel_ff) < NUM_LP) begin
               hrdata_ff <= {24'h00_0000, vec_ff[lpsel_ff]};
            end else begin
               hrdata_ff <= topo_pkg::RST_WORD;
            end
         end else begin
            hrdata_ff <= topo_pkg::RST_WORD;
         end
      end
   end

   // Query registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         leaf_ff <= topo_pkg::RST_WORD;
         sub_ff <= topo_pkg::RST_WORD;
         lpsel_ff <= '0;
      end else if (wr_ff) begin
         if (waddr_ff == topo_pkg::OFF_LEAF) begin
            leaf_ff <= hwdata;
         end else if (waddr_ff == topo_pkg::OFF_SUB) begin
            sub_ff <= hwdata;
         end else if (waddr_ff == topo_pkg::OFF_LPSEL) begin
            lpsel_ff <= hwdata[IW-1:0];
         end
      end
   end

   // External routing register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_ff <= 16'h0000;
         route_en_ff <= 1'b0;
      end else if (wr_ff && waddr_ff == topo_pkg::OFF_ROUTE) begin
         route_ff <= hwdata[15:0];
         route_en_ff <= hwdata[topo_pkg::ROUTE_EN_BIT];
      end
   end

   // Command write fires an interprocessor interrupt
   assign icr_fire = wr_ff && (waddr_ff == topo_pkg::OFF_ICR);
   assign icr_dest = hwdata[topo_pkg::ICR_DEST_LSB +: 8];
   assign icr_vec = hwdata[7:0];

   // External interrupt synchroniser and edge detect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
      end else begin
         ext_meta_ff <= ext_irq;
         ext_sync_ff <= ext_meta_ff;
         ext_prev_ff <= ext_sync_ff;
      end
   end
   assign ext_fire = ext_sync_ff && !ext_prev_ff && route_en_ff;

   // Per processor halt state and start vector
   for (genvar i = 0; i < NUM_LP; i++) begin : g_lp
      localparam logic [7:0] MY_ID = ID_BASE + 8'(i);
      localparam bit IS_BSP = (i == 0);
      logic hit_icr;
      logic hit_ext;
      assign hit_icr = icr_fire && (icr_dest == MY_ID);
      assign hit_ext = ext_fire && (route_ff[topo_pkg::ROUTE_DEST_LSB +: 8] == MY_ID);
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            halted_ff[i] <= !IS_BSP;
            vec_ff[i] <= topo_pkg::RST_VEC;
         end else if (halted_ff[i] && hit_icr) begin
            halted_ff[i] <= 1'b0;
            vec_ff[i] <= icr_vec;
         end else if (halted_ff[i] && hit_ext) begin
            halted_ff[i] <= 1'b0;
            vec_ff[i] <= route_ff[7:0];
         end
      end
      assign lp_vector[i*8 +: 8] = vec_ff[i];

      // Addressed command wakes this processor with its vector
      property p_wake;
         @(posedge clk) disable iff (rst)
         (icr_fire && icr_dest == MY_ID && halted_ff[i])
         |=> !lp_halted[i] && lp_vector[i*8 +: 8] == $past(icr_vec);
      endproperty
      a_wake: assert property (p_wake) else $error("ipi did not wake");
   end

   assign lp_halted = halted_ff;
   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Checks
   property p_mt_flag;
      @(posedge clk) disable iff (rst)
      (leaf_ff == topo_pkg::LEAF_FEAT && int'(lpsel_ff) < NUM_LP && MAX_LEAF >= 1)
      |-> res_d[topo_pkg::MT_FLAG_BIT] == MT_CAPABLE;
   endproperty
   a_mt_flag: assert property (p_mt_flag) else $error("mt flag wrong");

   property p_addr_lp;
      @(posedge clk) disable iff (rst)
      (leaf_ff == topo_pkg::LEAF_FEAT && int'(lpsel_ff) < NUM_LP && MAX_LEAF >= 1)
      |-> res_b[topo_pkg::ADDR_LP_LSB +: 8] >= 8'(NUM_LP) &&
          res_b[topo_pkg::ADDR_LP_LSB +: 8] != 8'h00;
   endproperty
   a_addr_lp: assert property (p_addr_lp) else $error("lp count wrong");

   property p_one_lp;
      @(posedge clk) disable iff (rst)
      (NUM_LP == 1 && leaf_ff == topo_pkg::LEAF_FEAT && lpsel_ff == '0 && MAX_LEAF >= 1)
      |-> res_b[topo_pkg::ADDR_LP_LSB +: 8] == 8'h01;
   endproperty
   a_one_lp: assert property (p_one_lp) else $error("single count wrong");

   property p_core;
      @(posedge clk) disable iff (rst)
      (leaf_ff == topo_pkg::LEAF_CORE && sub_ff < 32'(NUM_CACHE) &&
       int'(lpsel_ff) < NUM_LP && MAX_LEAF >= 4)
      |-> res_a[topo_pkg::CORE_LSB +: 6] == CORE_M1;
   endproperty
   a_core: assert property (p_core) else $error("core count wrong");

   property p_topo_zero;
      @(posedge clk) disable iff (rst)
      (!HAS_TOPO && leaf_ff == topo_pkg::LEAF_TOPO) |-> res_b == 32'h0000_0000;
   endproperty
   a_topo_zero: assert property (p_topo_zero) else $error("leaf 0b not zero");

   property p_topo_id;
      @(posedge clk) disable iff (rst)
      (HAS_TOPO && leaf_ff == topo_pkg::LEAF_TOPO && MAX_LEAF >= 11 &&
       int'(lpsel_ff) < NUM_LP) |-> res_d == {24'h00_0000, sel_id} && res_b != 0 ||
       sub_ff > 1;
   endproperty
   a_topo_id: assert property (p_topo_id) else $error("extended id wrong");

   property p_bsp;
      @(posedge clk) disable iff (rst)
      !lp_halted[0];
   endproperty
   a_bsp: assert property (p_bsp) else $error("bootstrap halted");

   property p_ext;
      @(posedge clk) disable iff (rst)
      ($rose(ext_sync_ff) && route_en_ff && !icr_fire &&
       route_ff[15:8] == ID_BASE + 8'(NUM_LP - 1) && halted_ff[NUM_LP-1])
      |=> !lp_halted[NUM_LP-1] && lp_vector[NUM_LP*8-1 -: 8] == $past(route_ff[7:0]);
   endproperty
   a_ext: assert property (p_ext) else $error("external route failed");

   property p_const;
      @(posedge clk) disable iff (rst)
      ($stable(leaf_ff) && $stable(sub_ff) && $stable(lpsel_ff))
      |-> $stable(res_a) && $stable(res_b) && $stable(res_c) && $stable(res_d);
   endproperty
   a_const: assert property (p_const) else $error("response not constant");

   property p_read;
      @(posedge clk) disable iff (rst)
      (addr_ok && !hwrite && haddr[7:0] == topo_pkg::OFF_RES_B) |=> hrdata == $past(res_b);
   endproperty
   a_read: assert property (p_read) else $error("read data wrong");

   c_wake: cover property (@(posedge clk) disable iff (rst) $fell(lp_halted[NUM_LP-1]));
   c_leaf1: cover property (@(posedge clk) disable iff (rst)
      addr_ok && !hwrite && haddr[7:0] == topo_pkg::OFF_RES_D && leaf_ff == 32'h1);
   c_ext: cover property (@(posedge clk) disable iff (rst) ext_fire);
   c_topo: cover property (@(posedge clk) disable iff (rst)
      addr_ok && !hwrite && haddr[7:0] == topo_pkg::OFF_RES_B && leaf_ff == topo_pkg::LEAF_TOPO);
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst, hsel, hwrite, ext_irq, alt;
   logic [31:0] haddr, hwdata, tmp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] res [4];
   logic [31:0] keep [4];
   wire logic [31:0] hrdata_a, hrdata_b;
   wire logic hready, hresp, ready_b, resp_b;
   wire logic [3:0] lp_halted;
   wire logic [31:0] lp_vector;
   int fails, checks_done;

   // Default four-processor package
   cpu_topology_enum i_dut (.clk(clk), .rst(rst), .hsel(hsel & !alt), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata_a), .hreadyout(hready), .hresp(hresp), .ext_irq(ext_irq),
      .lp_halted(lp_halted), .lp_vector(lp_vector));
   // Single processor, no extended leaf, higher basic leaf
   cpu_topology_enum #(.NUM_LP(1), .THREADS(1), .MAX_LEAF(32'h0000_000c), .HAS_TOPO(1'b0))
      i_one (.clk(clk), .rst(rst), .hsel(hsel & alt), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_b),
      .hreadyout(ready_b), .hresp(resp_b), .ext_irq(ext_irq), .lp_halted(), .lp_vector());

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait for hready high at a rising edge
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((alt ? ready_b : hready) !== 1'b1 && n < 50);
      if ((alt ? ready_b : hready) !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask

   // One single-word transfer, address phase then data phase
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      hsel <= 1'b1;
      haddr <= {24'h000000, addr};
      htrans <= topo_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= topo_pkg::HSIZE_WORD;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wdata;
      wait_ready();
      rdata = alt ? hrdata_b : hrdata_a;
      check("bus response", {31'h0, alt ? resp_b : hresp}, 32'h0);
   endtask

   // Select processor, leaf and subleaf, then read the four results
   task automatic query(input logic [31:0] lp, input logic [31:0] leaf, input logic [31:0] sub);
      xfer(1'b1, topo_pkg::OFF_LPSEL, lp, tmp);
      xfer(1'b1, topo_pkg::OFF_LEAF, leaf, tmp);
      xfer(1'b1, topo_pkg::OFF_SUB, sub, tmp);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, topo_pkg::OFF_RES_A + 8'(4 * i), 32'h0, res[i]);
      end
   endtask

   task automatic t_leaf1;
      for (int lp = 0; lp < 4; lp++) begin
         query(lp, topo_pkg::LEAF_FEAT, 0);
         check("mt flag", 32'(res[3][topo_pkg::MT_FLAG_BIT]), 32'h1);
         check("logical ids", 32'(res[1][23:16]), 32'h4);
         check("initial id", 32'(res[1][31:24]), 32'(lp));
         check("x2 flag", 32'(res[2][topo_pkg::X2_FLAG_BIT]), 32'h0);
      end
   endtask

   task automatic t_leaf4;
      // Software first confirms that leaf 4 exists
      query(0, topo_pkg::LEAF_BASIC, 0);
      check("leaf 4 present", 32'(res[0] >= topo_pkg::LEAF_CORE), 32'h1);
      for (int s = 0; s < 5; s++) begin
         query(1, topo_pkg::LEAF_CORE, s);
         check("core ids", 32'(res[0][31:26]), (s < 4) ? 32'h1 : 32'h0);
      end
   endtask

   task automatic t_topo;
      query(0, topo_pkg::LEAF_BASIC, 0);
      check("max leaf", res[0], 32'h0000_000b);
      for (int lp = 0; lp < 4; lp++) begin
         query(lp, topo_pkg::LEAF_TOPO, 0);
         check("smt count", res[1], 32'h2);
         check("x2 id", res[3], 32'(lp));
         query(lp, topo_pkg::LEAF_TOPO, 1);
         check("core level", res[1], 32'h4);
      end
   endtask

   task automatic t_repeat;
      query(3, topo_pkg::LEAF_FEAT, 0);
      keep = res;
      query(3, topo_pkg::LEAF_FEAT, 0);
      for (int i = 0; i < 4; i++) begin
         check("repeat query", res[i], keep[i]);
      end
      xfer(1'b0, 8'h40, 32'h0, tmp);
      check("unmapped read", tmp, 32'h0);
   endtask

   task automatic t_small;
      alt <= 1'b1;
      query(0, topo_pkg::LEAF_FEAT, 0);
      check("single mt flag", 32'(res[3][topo_pkg::MT_FLAG_BIT]), 32'h1);
      check("single count", 32'(res[1][23:16]), 32'h1);
      query(0, topo_pkg::LEAF_TOPO, 0);
      check("absent leaf", res[1], 32'h0);
      alt <= 1'b0;
   endtask

   task automatic t_ipi;
      xfer(1'b0, topo_pkg::OFF_STAT, 32'h0, tmp);
      check("halted at boot", 32'(tmp[3:0]), 32'he);
      check("bootstrap id", 32'(tmp[23:16]), 32'h0);
      xfer(1'b1, topo_pkg::OFF_ICR, 32'h0000_025a, tmp);
      xfer(1'b1, topo_pkg::OFF_ICR, 32'h0000_0277, tmp);
      xfer(1'b1, topo_pkg::OFF_LPSEL, 32'h2, tmp);
      xfer(1'b0, topo_pkg::OFF_VEC, 32'h0, tmp);
      check("woken vector", tmp, 32'h5a);
      check("vector pin", 32'(lp_vector[23:16]), 32'h5a);
      check("halted after ipi", 32'(lp_halted), 32'ha);
   endtask

   task automatic t_ext;
      int n;
      xfer(1'b1, topo_pkg::OFF_ROUTE, 32'h0001_0333, tmp);
      xfer(1'b0, topo_pkg::OFF_ROUTE, 32'h0, tmp);
      check("route readback", tmp, 32'h0001_0333);
      ext_irq <= 1'b1;
      n = 0;
      while (lp_halted[3] !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      check("ext wake", 32'(lp_halted), 32'h2);
      check("ext vector", 32'(lp_vector[31:24]), 32'h33);
      if (n == 20) begin
         fails++;
         conclude();
      end
      ext_irq <= 1'b0;
   endtask

   // Reset in mid-run restores boot state, bus usable right after
   task automatic t_reset;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      check("reset halted again", 32'(lp_halted), 32'he);
      check("reset vectors", lp_vector, 32'h0);
      rst <= 1'b0;
      @(posedge clk);
      xfer(1'b0, topo_pkg::OFF_STAT, 32'h0, tmp);
      check("status after reset", 32'(tmp[3:0]), 32'he);
   endtask

   // Reset, then the scenarios in turn
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = topo_pkg::HSIZE_WORD;
      hwdata = 32'h0;
      ext_irq = 1'b0;
      alt = 1'b0;
      fails = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      check("reset halted", 32'(lp_halted), 32'he);
      rst <= 1'b0;
      @(posedge clk);
      t_leaf1();
      t_leaf4();
      t_topo();
      t_repeat();
      t_small();
      t_ipi();
      t_ext();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire
